// File: hdl/bit_timer_regs.svh
// Purpose: Register offset, field positions, reset values for the interval timer
// Assumes: Byte-wide register port inside the microcontroller core
// Notes: Definitions only
`ifndef BIT_TIMER_REGS_SVH
`define BIT_TIMER_REGS_SVH
`define BIT_ADDR_CTRL 8'hec
`define BIT_CTRL_RESET 7'h17
`define BIT_F_SLEEP 6
`define BIT_F_RCGUARD 5
`define BIT_F_GUARD 4
`define BIT_F_CLEAR 3
`define BIT_F_DIV_HI 2
`define BIT_F_DIV_LO 0
`define BIT_PRESC_W 11
`define BIT_DIV_BASE 2
`define BIT_SLEEP_TAP 10
`endif

// File: hdl/bit_pkg.sv
// Purpose: Types shared by the interval timer files
// Assumes: Constants live in bit_timer_regs.svh
// Notes: Stop-mode encoding is one-hot
package bit_pkg;
	typedef enum logic [2:0] {
		BIT_RUN = 3'h1,
		BIT_SLEEP = 3'h2,
		BIT_RCGUARD = 3'h4
	} bit_mode_t;
endpackage

// File: hdl/bit_prescaler.sv
// Purpose: Free-running oscillator divider with a selectable tap pulse
// Assumes: One clock, asynchronous active-low reset
// Notes: Tap pulse is one cycle wide on the rising edge of the chosen stage
`include "bit_timer_regs.svh"
module bit_prescaler #(
	parameter int W = `BIT_PRESC_W
) (
	// Clock and reset
	input wire logic i_mclk,
	input wire logic i_rst_b,
	// Tap select
	input wire logic [2:0] i_sel,
	// Pulses
	output logic o_tick,
	output logic o_sleep_tick
);
	typedef struct packed {
		logic [W-1:0] cnt;
	} bit_presc_st_t;
	bit_presc_st_t st_q, st_d;
	logic [W-1:0] nxt;
	logic [W-1:0] rise;
	always_comb begin
		nxt = st_q.cnt + {{(W-1){1'b0}}, 1'b1};
		rise = nxt & ~st_q.cnt;
		st_d.cnt = nxt;
	end
	// Tap 000 is divide by 8, each code doubles, 111 is divide by 1024
	assign o_tick = rise[`BIT_DIV_BASE + i_sel];
	assign o_sleep_tick = rise[`BIT_SLEEP_TAP];
	always_ff @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end
endmodule

// File: hdl/bit_interval_timer.sv
// Purpose: Free-running 8-bit interval counter with stop-mode control word
// Assumes: CPU core gives a byte port with read and write strobes and a stop strobe
// Notes: Address reads the count and writes the control word
`include "bit_timer_regs.svh"
// Behaviour
// - Eight-bit counter runs freely; nothing in software can halt it.
// - Counter steps once per prescaler pulse, ratio 8 to 1024.
// - Three-bit select picks tap: 000 divide 8, doubling, 111 divide 1024.
// - Rollover from ff to 00 sets the overflow interrupt flag.
// - Writing one to clear bit zeros the counter, then counting resumes.
// - Clear bit returns to zero by itself one cycle later.
// - Stop with sleep enable set enters wake-up timer mode.
// - Wake-up mode keeps only oscillator, divide-2048 tap and timer 0 alive.
// - Stop with RC guard enable set and sleep enable clear enters RC watchdog mode.
// - RC watchdog mode keeps RC oscillator, this timer, watchdog alive.
// - Guard select picks watchdog when one, plain 8-bit timer when zero.
// - One address: read returns count, write loads control word.
// - Reset control word is 0010111: guard on, divide 1024.
module bit_interval_timer (
	// Clock and reset
	input wire logic i_mclk,
	input wire logic i_rst_b,
	// Register port
	input wire logic [7:0] i_addr,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [7:0] i_wdata,
	output logic [7:0] o_rdata,
	output logic o_rsel,
	// Stop and wake
	input wire logic i_stop,
	input wire logic i_wake,
	input wire logic i_ovf_ack,
	// Status and control outputs
	output logic o_ovf_flag,
	output logic o_tick,
	output logic o_sleep_tick,
	output logic o_guard_sel,
	output bit_pkg::bit_mode_t o_mode,
	output logic o_keep_timer0,
	output logic o_keep_rc_osc,
	output logic o_keep_guard,
	output logic o_halt_other
);
	import bit_pkg::*;
	typedef struct packed {
		logic [7:0] count;
		logic [6:0] ctrl;
		logic flag;
		bit_mode_t mode;
		logic [7:0] rdata;
	} bit_st_t;
	bit_st_t st_q, st_d;
	logic tick;
	logic sleep_tick;
	logic hit;
	logic [3:0] keep;
	// One address compare, shared by the read and the write strobe
	function automatic logic bit_hit(input logic [7:0] addr);
		bit_hit = (addr == `BIT_ADDR_CTRL);
	endfunction
	// Which parts stay alive per mode, as {timer0, rc osc, guard, halt}
	function automatic logic [3:0] bit_keep(input bit_mode_t mode);
		logic [3:0] k;
		k = 4'h0;
		unique case (mode)
			BIT_RUN: begin
				k = 4'ha;
			end
			BIT_SLEEP: begin
				// Wake-up timer keeps timer 0 and the long tap only
				k = 4'h9;
			end
			BIT_RCGUARD: begin
				// Watchdog clock source has to survive here
				k = 4'h7;
			end
			default: begin
				k = 4'hb;
			end
		endcase
		bit_keep = k;
	endfunction
	bit_prescaler #(
		.W(`BIT_PRESC_W)
	) u_presc (
		.i_mclk(i_mclk),
		.i_rst_b(i_rst_b),
		.i_sel(st_q.ctrl[`BIT_F_DIV_HI:`BIT_F_DIV_LO]),
		.o_tick(tick),
		.o_sleep_tick(sleep_tick)
	);
	// Read-modify-write bit ops would copy the count into the control word
	assign hit = bit_hit(i_addr);
	always_comb begin
		st_d = st_q;
		// Clear bit lasts exactly one cycle
		st_d.ctrl[`BIT_F_CLEAR] = 1'b0;
		// Only the count advances; no control bit gates it
		if (st_q.ctrl[`BIT_F_CLEAR]) begin
			st_d.count = 8'h00;
		end else if (tick) begin
			st_d.count = st_q.count + 8'h01;
		end
		if (i_ovf_ack) begin
			st_d.flag = 1'b0;
		end
		// Set beats acknowledge in the same cycle
		if (tick && !st_q.ctrl[`BIT_F_CLEAR] && st_q.count == 8'hff) begin
			st_d.flag = 1'b1;
		end
		if (hit && i_wr) begin
			st_d.ctrl = i_wdata[6:0];
		end
		if (hit && i_rd) begin
			st_d.rdata = st_q.count;
		end
		unique case (st_q.mode)
			BIT_RUN: begin
				if (i_stop && st_q.ctrl[`BIT_F_SLEEP]) begin
					st_d.mode = BIT_SLEEP;
				end else if (i_stop && st_q.ctrl[`BIT_F_RCGUARD]) begin
					st_d.mode = BIT_RCGUARD;
				end
			end
			BIT_SLEEP, BIT_RCGUARD: begin
				if (i_wake) begin
					st_d.mode = BIT_RUN;
				end
			end
			default: begin
				st_d.mode = BIT_RUN;
			end
		endcase
	end
	always_ff @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			st_q.count <= 8'h00;
			st_q.ctrl <= `BIT_CTRL_RESET;
			st_q.flag <= 1'b0;
			st_q.mode <= BIT_RUN;
			st_q.rdata <= 8'h00;
		end else begin
			st_q <= st_d;
		end
	end
	assign o_rdata = st_q.rdata;
	assign o_rsel = hit && i_rd;
	assign o_ovf_flag = st_q.flag;
	assign o_tick = tick;
	assign o_sleep_tick = sleep_tick;
	assign o_guard_sel = st_q.ctrl[`BIT_F_GUARD];
	assign o_mode = st_q.mode;
	// Halting is only reported; the counter itself never stops
	assign keep = bit_keep(st_q.mode);
	assign o_keep_timer0 = keep[3];
	assign o_keep_rc_osc = keep[2];
	assign o_keep_guard = keep[1];
	assign o_halt_other = keep[0];
endmodule

// File: tb/bit_interval_timer_chk.sv
// Purpose: Port checker for the interval timer
// Assumes: Sees the top-level ports only
// Notes: Tick spacing after a tap change may shrink, so only one quiet cycle is required
module bit_chk import bit_pkg::*; (
	input wire logic i_mclk, i_rst_b, i_wr, i_rd, i_ovf_ack,
	input wire logic [7:0] i_addr, i_wdata,
	input wire logic o_rsel, o_ovf_flag, o_tick, o_sleep_tick, o_guard_sel,
	input wire logic o_keep_timer0, o_keep_rc_osc, o_keep_guard, o_halt_other,
	input wire bit_mode_t o_mode
);
	default clocking @(posedge i_mclk); endclocking
	default disable iff (!i_rst_b);
	property p_rsel; o_rsel == (i_rd && i_addr == 8'hec); endproperty
	a_rsel: assert property (p_rsel) else $error("rsel");
	property p_wsel; i_wr && i_addr == 8'hec |=> o_guard_sel == $past(i_wdata[4]); endproperty
	a_wsel: assert property (p_wsel) else $error("guard select");
	property p_rst; $rose(i_rst_b) |-> o_guard_sel; endproperty
	a_rst: assert property (p_rst) else $error("reset word");
	property p_ovf; $rose(o_ovf_flag) |-> $past(o_tick); endproperty
	a_ovf: assert property (p_ovf) else $error("flag cause");
	property p_hold; o_ovf_flag && !i_ovf_ack |=> o_ovf_flag; endproperty
	a_hold: assert property (p_hold) else $error("flag lost");
	property p_tick; o_tick |=> !o_tick; endproperty
	a_tick: assert property (p_tick) else $error("tick rate");
	property p_slt; o_sleep_tick |=> !o_sleep_tick [*8]; endproperty
	a_slt: assert property (p_slt) else $error("sleep tick");
	property p_slp; o_mode == BIT_SLEEP |-> o_keep_timer0 && o_halt_other && !o_keep_guard
		&& !o_keep_rc_osc; endproperty
	a_slp: assert property (p_slp) else $error("sleep keep");
	property p_rc; o_mode == BIT_RCGUARD |-> o_keep_rc_osc && o_keep_guard && o_halt_other
		&& !o_keep_timer0; endproperty
	a_rc: assert property (p_rc) else $error("rc keep");
	c_ovf: cover property ($rose(o_ovf_flag));
	c_slp: cover property (o_mode == BIT_SLEEP);
	c_rc: cover property (o_mode == BIT_RCGUARD);
endmodule
bind bit_interval_timer bit_chk u_chk(.*);

// File: tb/bit_interval_timer_tb_top.sv
// Purpose: Self-checking bench for the interval timer
// Assumes: 20 MHz clock, full-length prescaler
// Notes: A tap period is timed after two ticks, so a tap change glitch is skipped
module bit_interval_timer_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import bit_pkg::*;
	logic clk = 0, rst_b = 0, wr = 0, rd = 0, stop = 0, wake = 0, ack = 0;
	logic [7:0] addr = 8'hec, wd = 8'h00, rdata, v;
	logic rsel, flag, tick, stick, gsel, k0, k1, k2, halt;
	logic [15:0] p;
	bit_mode_t mode;
	int n_fail = 0, comparisons = 0;
	always #25 clk = ~clk;
	bit_interval_timer dut(.i_mclk(clk), .i_rst_b(rst_b), .i_addr(addr), .i_wr(wr),
		.i_rd(rd), .i_wdata(wd), .o_rdata(rdata), .o_rsel(rsel), .i_stop(stop),
		.i_wake(wake), .i_ovf_ack(ack), .o_ovf_flag(flag), .o_tick(tick),
		.o_sleep_tick(stick), .o_guard_sel(gsel), .o_mode(mode), .o_keep_timer0(k0),
		.o_keep_rc_osc(k1), .o_keep_guard(k2), .o_halt_other(halt));
	task chk(input logic [15:0] s, e);
		comparisons++;
		if (s !== e) begin
			n_fail++;
			$display("BAD t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task summarize;
		$display("n_fail=%0d comparisons=%0d", n_fail, comparisons);
		if (n_fail == 0 && comparisons > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	task wrb(input logic [7:0] a, d);
		@(posedge clk); addr <= a; wd <= d; wr <= 1'b1;
		@(posedge clk); wr <= 1'b0;
	endtask
	task rdb;
		@(posedge clk); addr <= 8'hec; rd <= 1'b1;
		@(posedge clk); rd <= 1'b0;
		@(posedge clk); v = rdata;
	endtask
	task strobe(input logic s);
		@(posedge clk); stop <= s; wake <= !s;
		@(posedge clk); stop <= 1'b0; wake <= 1'b0;
		@(posedge clk);
	endtask
	task wt;
		do @(posedge clk); while (tick !== 1'b1);
	endtask
	task t_div;
		for (int c = 0; c < 8; c++) begin
			wrb(8'hec, 8'(c));
			@(posedge clk); chk(16'(gsel), 16'h0);
			wt; wt; p = 0;
			do begin @(posedge clk); p++; end while (tick !== 1'b1);
			chk(p, 16'h8 << c);
		end
	endtask
	task t_clr;
		// Align to a divide-8 tick first so no tick falls inside the read window
		wrb(8'hec, 8'h00); wt;
		wrb(8'hec, 8'h08); @(posedge clk);
		rdb; chk(16'(v), 16'h0);
		p = 0;
		while (flag !== 1'b1 && p < 3000) begin @(posedge clk); p++; end
		chk(16'(p > 2030 && p < 2060), 16'h1);
		rdb; chk(16'(v), 16'h0);
		@(posedge clk); ack <= 1'b1; @(posedge clk); ack <= 1'b0; @(posedge clk);
		chk(16'(flag), 16'h0);
	endtask
	task t_mode;
		wrb(8'hec, 8'h57); strobe(1); chk(16'(mode), 16'(BIT_SLEEP));
		strobe(0); chk(16'(mode), 16'(BIT_RUN));
		wrb(8'hec, 8'h27); strobe(1); chk(16'(mode), 16'(BIT_RCGUARD));
		strobe(0); wrb(8'h00, 8'h10); @(posedge clk); chk(16'(gsel), 16'h0);
	endtask
	initial begin
		repeat (5) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk); chk(16'(gsel), 16'h1);
		t_div; t_clr; t_mode; summarize;
	end
	initial begin
		#2000000; n_fail++; summarize;
	end
endmodule
